// ===== hw/mie_pkg.sv
// Purpose: Shared constants and types for the move instruction executor.
// Assumes: 12-bit program words, 8-bit data path, 32 directly indexed files.
// Notes: Encodings and field positions are defined here; the checks and bench also hard-code some slices.
`default_nettype none
package mie_pkg;
   localparam int INSTR_W = 12;
   localparam int DATA_W = 8;
   localparam int FILE_W = 5;
   // Copy-file word is 0010 00df ffff; top six bits must match.
   localparam logic [5:0] COPY_FILE_OP = 6'h08;
   localparam int COPY_TOP_MSB = 11;
   localparam int COPY_TOP_LSB = 6;
   localparam int DEST_BIT = 5;
   // Load-literal word is 1100 kkkk kkkk.
   localparam logic [3:0] LOAD_LITERAL_OP = 4'hc;
   localparam int LIT_TOP_MSB = 11;
   localparam int LIT_TOP_LSB = 8;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   // Oscillator periods per instruction cycle.
   localparam int OSC_PER_CYCLE = 4;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [1:0] PHASE_LAST = 2'h2;

   typedef struct packed {
      logic we;
      logic [FILE_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mie_file_wr_t;
endpackage : mie_pkg
`default_nettype wire

// ===== hw/mie_core.sv
// Purpose: Decode and execute the copy-file and load-literal instructions.
// Assumes: ref_clk is the oscillator time base; file read data is
//          combinational from file_raddr; instr is held for a cycle.
// Notes: Fully static; all state is plain flip-flops, so the clock may stop.
`default_nettype none
module mie_core (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [mie_pkg::INSTR_W-1:0] instr,
   input wire logic [mie_pkg::DATA_W-1:0] file_rdata,
   output logic [mie_pkg::FILE_W-1:0] file_raddr,
   output mie_pkg::mie_file_wr_t file_wr,
   output logic [mie_pkg::DATA_W-1:0] acc,
   output logic zero_flag,
   output logic cycle_start
);
   // =========================================================
   // Instruction phase sequencer
   typedef enum logic [1:0] {
      MIE_Q1 = 2'b00, MIE_Q2 = 2'b01, MIE_Q3 = 2'b11, MIE_Q4 = 2'b10
   } mie_phase_t;
   mie_phase_t phase_q;
   logic is_copy, is_lit, dest;
   logic [mie_pkg::INSTR_W-1:0] instr_q;

   assign is_copy = instr_q[mie_pkg::COPY_TOP_MSB:mie_pkg::COPY_TOP_LSB]
                    == mie_pkg::COPY_FILE_OP;
   assign is_lit = instr_q[mie_pkg::LIT_TOP_MSB:mie_pkg::LIT_TOP_LSB]
                   == mie_pkg::LOAD_LITERAL_OP;
   assign dest = instr_q[mie_pkg::DEST_BIT];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phase_q <= MIE_Q1;
      end else begin
         unique case (phase_q)
            MIE_Q1: phase_q <= MIE_Q2;
            MIE_Q2: phase_q <= MIE_Q3;
            MIE_Q3: phase_q <= MIE_Q4;
            MIE_Q4: phase_q <= MIE_Q1;
         endcase
      end
   end

   // =========================================================
   // Oscillator period count
   // Kept beside the Gray sequencer so the checks can compare two
   // independent views of where the instruction cycle stands; a stuck
   // or skipped phase code then shows up as a disagreement.
   logic [1:0] osc_cnt_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         osc_cnt_q <= 2'h0;
      end else if (osc_cnt_q == 2'(mie_pkg::OSC_PER_CYCLE - 1)) begin
         osc_cnt_q <= 2'h0;
      end else begin
         osc_cnt_q <= osc_cnt_q + 2'h1;
      end
   end

   // =========================================================
   // Fetch latch; the word is captured at Q1 and held all cycle.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         instr_q <= '0;
         cycle_start <= 1'b0;
      end else begin
         cycle_start <= (phase_q == MIE_Q4);
         if (phase_q == MIE_Q1) begin
            instr_q <= instr;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         file_raddr <= '0;
      end else if (phase_q == MIE_Q2) begin
         file_raddr <= instr_q[mie_pkg::FILE_W-1:0];
      end
   end

   // =========================================================
   // Execute at Q4 so the read address has settled one phase earlier.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         acc <= mie_pkg::ACC_RESET;
         zero_flag <= 1'b0;
         file_wr <= '0;
      end else begin
         file_wr.we <= 1'b0;
         if (phase_q == MIE_Q4 && is_copy) begin
            zero_flag <= (file_rdata == '0);
            if (dest == mie_pkg::DEST_ACC) begin
               acc <= file_rdata;
            end else begin
               file_wr.we <= 1'b1;
               file_wr.addr <= file_raddr;
               file_wr.data <= file_rdata;
            end
         end else if (phase_q == MIE_Q4 && is_lit) begin
            acc <= instr_q[mie_pkg::DATA_W-1:0];
         end
      end
   end
   // Nothing here depends on clock rate, so any stop or slowdown is safe.

   // =========================================================
   // Checks
   cycle_period_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cycle_start |=> !cycle_start [*3] ##1 cycle_start)
      else $error("instruction cycle is not four periods");
   copy_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase_q == MIE_Q4 && is_copy && !dest) |=>
         acc == $past(file_rdata))
      else $error("copy to accumulator wrong");
   copy_back_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase_q == MIE_Q4 && is_copy && dest) |=> file_wr.we &&
         file_wr.data == $past(file_rdata) &&
         file_wr.addr == $past(instr_q[4:0]))
      else $error("copy write back wrong");
   copy_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase_q == MIE_Q4 && is_copy) |=>
         zero_flag == ($past(file_rdata) == 8'h00))
      else $error("zero flag wrong");
   lit_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase_q == MIE_Q4 && is_lit) |=>
         acc == $past(instr_q[7:0]) && $stable(zero_flag))
      else $error("literal load wrong");
   hold_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase_q != MIE_Q4) |=> $stable(acc) && $stable(zero_flag))
      else $error("state changed outside execute");
   we_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      file_wr.we |=> !file_wr.we)
      else $error("write strobe longer than one period");
   no_acc_wb_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase_q == MIE_Q4 && is_copy && dest) |=> $stable(acc))
      else $error("write back touched accumulator");

   // =========================================================
   // Read address and fetch checks
   // The file read port is combinational, so the index must be steady
   // from the third phase through execute or the moved value is torn.
   raddr_load_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (phase_q == MIE_Q2) |=>
         file_raddr == $past(instr_q[mie_pkg::FILE_W-1:0]))
      else $error("read index not taken from the word");
   raddr_hold_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (phase_q != MIE_Q2) |=> $stable(file_raddr))
      else $error("read index moved inside the cycle");
   fetch_hold_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (phase_q != MIE_Q1) |=> $stable(instr_q))
      else $error("instruction word changed inside the cycle");

   // =========================================================
   // Cycle timing checks
   phase_wrap_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (phase_q == MIE_Q4) |=> (phase_q == MIE_Q1))
      else $error("phase sequence did not wrap after execute");
   phase_track_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (osc_cnt_q == 2'h0) == (phase_q == MIE_Q1))
      else $error("phase code disagrees with period count");
   start_phase_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      cycle_start |-> (phase_q == MIE_Q1))
      else $error("cycle start pulse in the wrong phase");
   start_due_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (phase_q == MIE_Q4) |=> cycle_start)
      else $error("cycle start pulse missing after execute");

   // =========================================================
   // Execute checks
   // Only a copy with the file target may raise the write strobe; any
   // other word leaving a strobe behind would corrupt a file register.
   we_source_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      $rose(file_wr.we) |-> ($past(phase_q) == MIE_Q4))
      else $error("write strobe raised outside execute");
   acc_no_wr_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (phase_q == MIE_Q4 && is_copy && !dest) |=> !file_wr.we)
      else $error("copy to accumulator wrote a file");
   lit_no_wr_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (phase_q == MIE_Q4 && is_lit) |=> !file_wr.we)
      else $error("literal load wrote a file");
   other_op_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (phase_q == MIE_Q4 && !is_copy && !is_lit) |=>
         $stable(acc) && $stable(zero_flag) && !file_wr.we)
      else $error("unhandled word changed state");
   decode_excl_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      !(is_copy && is_lit))
      else $error("word decoded as both moves");

   // =========================================================
   // Reset check
   // Reset is sampled on the clock, so after a low level acc, zero_flag,
   // the write strobe and cycle_start must sit idle on the very next edge.
   reset_idle_a: assert property (@(posedge ref_clk)
      !rst_n |=> acc == mie_pkg::ACC_RESET && !zero_flag &&
         !file_wr.we && !cycle_start)
      else $error("outputs not idle after reset");
endmodule : mie_core
`default_nettype wire

// ===== testbench/tb_move_instruction_exec.sv
// Purpose: Self-checking bench for the move instruction executor.
// Assumes: One instruction per four clocks, results seen a slot later.
// Notes: The bench array stands in for the file registers.
`default_nettype none
// ==========================================================
// Bench
module tb_move_instruction_exec;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b1;
   logic [11:0] instr = 12'h000;
   logic [7:0] regs [32];
   logic [4:0] file_raddr;
   mie_pkg::mie_file_wr_t file_wr, wr_seen;
   logic [7:0] acc, e_acc;
   logic [13:0] e_wr;
   logic zero_flag, cycle_start, e_z, e_we, pend;
   int bad_count = 0, samples_checked = 0, cycles = 0, wr_cnt = 0;
   always #10 ref_clk = run ? ~ref_clk : ref_clk;
   mie_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr),
      .file_rdata(regs[file_raddr]), .file_raddr(file_raddr),
      .file_wr(file_wr), .acc(acc), .zero_flag(zero_flag),
      .cycle_start(cycle_start));
   always @(posedge ref_clk) begin
      cycles++;
      if (file_wr.we === 1'b1) begin
         wr_seen = file_wr;
         wr_cnt++;
      end
      if (cycles == 3000) begin
         bad_count++;
         finish_test;
      end
   end
   task automatic finish_test;
      if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Issues one instruction, then checks the previous slot's results.
   task automatic slot(input logic [11:0] ins);
      logic [7:0] v;
      v = regs[ins[4:0]];
      check(16'(cycle_start), 16'(pend));
      instr <= ins;
      @(posedge ref_clk);
      @(negedge ref_clk) check(16'(cycle_start), 16'h0000);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk) check(16'(cycle_start), 16'h0000);
      if (pend) begin
         check(16'(acc), 16'(e_acc));
         check(16'(zero_flag), 16'(e_z));
         check(16'(wr_cnt), 16'(e_we));
         if (e_we) check(16'(wr_seen), 16'(e_wr));
      end
      wr_cnt = 0;
      if (ins[11:6] == mie_pkg::COPY_FILE_OP) begin
         check(16'(file_raddr), 16'(ins[4:0]));
         e_z = (v == 8'h00);
         e_we = ins[mie_pkg::DEST_BIT];
         e_wr = {1'b1, ins[4:0], v};
         if (!e_we) e_acc = v;
      end else begin
         e_we = 1'b0;
         if (ins[11:8] == mie_pkg::LOAD_LITERAL_OP) e_acc = ins[7:0];
      end
      pend = 1'b1;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   initial begin
      for (int i = 0; i < 32; i++) regs[i] = 8'(i * 37 + 5);
      regs[0] = 8'h00;
      regs[3] = 8'h00;
      pend = 1'b0;
      e_acc = mie_pkg::ACC_RESET;
      e_z = 1'b0;
      repeat (6) @(negedge ref_clk);
      rst_n <= 1'b1;
      slot(12'hca5);
      slot(12'h203);
      slot(12'hcff);
      slot(12'h23f);
      slot(12'h103);
      // The clock halts for a long spell; every state must survive it.
      run = 1'b0;
      #1005;
      run = 1'b1;
      slot(12'h220);
      slot(12'h000);
      finish_test;
   end
endmodule // tb_move_instruction_exec
`default_nettype wire
